// file: rtl/piu_consts.vh
// constants of the prioritized interrupt unit
`ifndef PIU_CONSTS_VH
`define PIU_CONSTS_VH
// ----------------------------------------
// register indices, byte address is four times the index
// ----------------------------------------
`define PIU_IDX_PRI_A 18'h0ff20
`define PIU_IDX_PRI_B 18'h0ff21
`define PIU_IDX_TICK_EN 18'h0ff22
`define PIU_IDX_SER_EN 18'h0ff23
`define PIU_IDX_KEY_EN 18'h0ff24
`define PIU_IDX_TMR_EN 18'h0ff25
`define PIU_IDX_TICK_PEND 18'h0ff26
`define PIU_IDX_SER_PEND 18'h0ff27
`define PIU_IDX_KEY_PEND 18'h0ff28
`define PIU_IDX_TMR_PEND 18'h0ff29
`define PIU_IDX_KEY_EDGE 18'h0ff2a
`define PIU_IDX_CPU_MASK 18'h0ff2b
// ----------------------------------------
// reset values and writable bit masks
// ----------------------------------------
`define PIU_RST_BYTE 8'h00
`define PIU_WMASK_PRI_B 8'hfc
`define PIU_WMASK_TICK_EN 8'hff
`define PIU_WMASK_SER 8'h07
`define PIU_WMASK_TICK_PEND 8'h7f
`define PIU_WMASK_FULL 8'hff
// ----------------------------------------
// priority field positions (low bit of each 2-bit field)
// ----------------------------------------
`define PIU_POS_KEY_PRI 6
`define PIU_POS_SER_PRI 4
`define PIU_POS_SW_PRI 2
`define PIU_POS_CT_PRI 0
`define PIU_POS_T10_PRI 2
`define PIU_POS_T32_PRI 4
// ----------------------------------------
// vectors, low byte of the fixed 2-byte slot address
// ----------------------------------------
`define PIU_VEC_NMI 8'h04
`define PIU_VEC_BASE 8'h06
`define PIU_VEC_SKIP 8'h08
`define PIU_SRC_GAP 16
`define PIU_NUM_SRC 26
`define PIU_LVL_NMI 3'h4
`define PIU_MASK_NMI 2'h3
`define PIU_STK_DEPTH 3'h4
// ----------------------------------------
// bus answers
// ----------------------------------------
`define PIU_RESP_OKAY 2'h0
`define PIU_RESP_SLVERR 2'h2
`endif

// file: rtl/piu_top.v
// prioritized interrupt unit with axi4-lite register slave
`default_nettype none
`include "piu_consts.vh"

module piu_top (
  // clock and reset
  input wire i_mclk,
  input wire i_nrst,
  // axi4-lite write address
  input wire i_awvalid,
  output reg o_awready_ff,
  input wire [19:0] i_awaddr,
  // axi4-lite write data
  input wire i_wvalid,
  output reg o_wready_ff,
  input wire [31:0] i_wdata,
  input wire [3:0] i_wstrb,
  // axi4-lite write response
  output reg o_bvalid_ff,
  input wire i_bready,
  output reg [1:0] o_bresp_ff,
  // axi4-lite read address
  input wire i_arvalid,
  output reg o_arready_ff,
  input wire [19:0] i_araddr,
  // axi4-lite read data
  output reg o_rvalid_ff,
  input wire i_rready,
  output reg [31:0] o_rdata_ff,
  output reg [1:0] o_rresp_ff,
  // interrupt sources
  input wire [7:0] i_key_pin,
  input wire [3:0] i_tmr_underflow,
  input wire [3:0] i_tmr_match,
  input wire i_ser_error,
  input wire i_ser_rx_done,
  input wire i_ser_tx_done,
  input wire [2:0] i_stopwatch_sig,
  input wire [3:0] i_clocktimer_sig,
  input wire i_wdt_nmi,
  // cpu side
  input wire i_opfetch_first,
  input wire i_return_from_exception,
  input wire i_max_mode,
  input wire i_mask_wr,
  input wire [1:0] i_mask_wdata,
  output reg o_exc_ff,
  output reg [7:0] o_vector_ff,
  output reg [2:0] o_level_ff,
  output reg o_push_bank_ff,
  output reg [1:0] o_cpu_mask_ff
);

  // ----------------------------------------
  // declarations
  // ----------------------------------------
  reg [7:0] pri_a_ff;
  reg [7:0] pri_b_ff;
  reg [7:0] tick_en_ff;
  reg [7:0] ser_en_ff;
  reg [7:0] key_en_ff;
  reg [7:0] tmr_en_ff;
  reg [7:0] tick_pend_ff;
  reg [7:0] ser_pend_ff;
  reg [7:0] key_pend_ff;
  reg [7:0] tmr_pend_ff;
  reg [7:0] key_edge_ff;
  reg [7:0] key_sync1_ff;
  reg [7:0] key_sync2_ff;
  reg [7:0] key_prev_ff;
  reg [2:0] sw_prev_ff;
  reg [3:0] ct_prev_ff;
  reg nmi_pend_ff;
  reg [17:0] aw_idx_ff;
  reg aw_hold_ff;
  reg [7:0] wdata_ff;
  reg wstrb0_ff;
  reg w_hold_ff;
  reg [1:0] mask_stk_ff [0:3];
  reg [2:0] stk_ptr_ff;
  wire wr_go;
  wire wr_hit;
  wire [7:0] key_edge;
  wire [7:0] tick_set;
  wire [7:0] ser_set;
  wire [7:0] tmr_set;
  wire [7:0] tick_clr;
  wire [7:0] ser_clr;
  wire [7:0] key_clr;
  wire [7:0] tmr_clr;
  wire [`PIU_NUM_SRC-1:0] req;
  wire [2*`PIU_NUM_SRC-1:0] lvl;
  reg [1:0] best_lvl;
  reg [7:0] best_vec;
  reg best_hit;
  reg [7:0] rd_mux;
  reg rd_hit;
  wire accept;
  wire take_nmi;
  integer i;
  integer j;

  // ----------------------------------------
  // axi4-lite write channel
  // ----------------------------------------
  // address and data are taken in either order, committed once both held
  assign wr_go = aw_hold_ff & w_hold_ff & ~o_bvalid_ff;

  always @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_awready_ff <= 1'b1;
      o_wready_ff <= 1'b1;
      o_bvalid_ff <= 1'b0;
      o_bresp_ff <= `PIU_RESP_OKAY;
      aw_idx_ff <= 18'h00000;
      aw_hold_ff <= 1'b0;
      wdata_ff <= `PIU_RST_BYTE;
      wstrb0_ff <= 1'b0;
      w_hold_ff <= 1'b0;
    end else begin
      if (i_awvalid && o_awready_ff) begin
        aw_idx_ff <= i_awaddr[19:2];
        aw_hold_ff <= 1'b1;
        o_awready_ff <= 1'b0;
      end
      if (i_wvalid && o_wready_ff) begin
        wdata_ff <= i_wdata[7:0];
        wstrb0_ff <= i_wstrb[0];
        w_hold_ff <= 1'b1;
        o_wready_ff <= 1'b0;
      end
      if (wr_go) begin
        o_bvalid_ff <= 1'b1;
        o_bresp_ff <= wr_hit ? `PIU_RESP_OKAY : `PIU_RESP_SLVERR;
        aw_hold_ff <= 1'b0; // both halves consumed by this write
        w_hold_ff <= 1'b0;
      end
      if (o_bvalid_ff && i_bready) begin
        o_bvalid_ff <= 1'b0;
        o_awready_ff <= 1'b1;
        o_wready_ff <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // address decode
  // ----------------------------------------
  // mapped indices answer okay, anything else slverr
  assign wr_hit = (aw_idx_ff >= `PIU_IDX_PRI_A) && (aw_idx_ff <= `PIU_IDX_CPU_MASK);

  // read data selection, data in low byte, upper bits zero
  always @* begin
    rd_hit = 1'b1;
    case (i_araddr[19:2])
      `PIU_IDX_PRI_A: rd_mux = pri_a_ff;
      `PIU_IDX_PRI_B: rd_mux = pri_b_ff;
      `PIU_IDX_TICK_EN: rd_mux = tick_en_ff;
      `PIU_IDX_SER_EN: rd_mux = ser_en_ff;
      `PIU_IDX_KEY_EN: rd_mux = key_en_ff;
      `PIU_IDX_TMR_EN: rd_mux = tmr_en_ff;
      `PIU_IDX_TICK_PEND: rd_mux = tick_pend_ff;
      `PIU_IDX_SER_PEND: rd_mux = ser_pend_ff;
      `PIU_IDX_KEY_PEND: rd_mux = key_pend_ff;
      `PIU_IDX_TMR_PEND: rd_mux = tmr_pend_ff;
      `PIU_IDX_KEY_EDGE: rd_mux = key_edge_ff;
      `PIU_IDX_CPU_MASK: rd_mux = {6'h00, o_cpu_mask_ff};
      default: begin
        rd_mux = `PIU_RST_BYTE;
        rd_hit = 1'b0;
      end
    endcase
  end

  // ----------------------------------------
  // axi4-lite read channel
  // ----------------------------------------
  // reads have no side effect, data registered at the address handshake
  always @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_arready_ff <= 1'b1;
      o_rvalid_ff <= 1'b0;
      o_rdata_ff <= 32'h00000000;
      o_rresp_ff <= `PIU_RESP_OKAY;
    end else begin
      if (i_arvalid && o_arready_ff) begin
        o_rdata_ff <= {24'h000000, rd_mux};
        o_rresp_ff <= rd_hit ? `PIU_RESP_OKAY : `PIU_RESP_SLVERR;
        o_rvalid_ff <= 1'b1;
        o_arready_ff <= 1'b0;
      end
      if (o_rvalid_ff && i_rready) begin
        o_rvalid_ff <= 1'b0;
        o_arready_ff <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // source edge detection
  // ----------------------------------------
  // key pins are asynchronous: two-stage sync, then edge compare
  always @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      key_sync1_ff <= `PIU_RST_BYTE;
      key_sync2_ff <= `PIU_RST_BYTE;
      key_prev_ff <= `PIU_RST_BYTE;
      sw_prev_ff <= 3'h0;
      ct_prev_ff <= 4'h0;
    end else begin
      key_sync1_ff <= i_key_pin;
      key_sync2_ff <= key_sync1_ff;
      key_prev_ff <= key_sync2_ff;
      sw_prev_ff <= i_stopwatch_sig;
      ct_prev_ff <= i_clocktimer_sig;
    end
  end

  // edge select 1 picks falling, 0 picks rising
  assign key_edge = (key_edge_ff & key_prev_ff & ~key_sync2_ff) |
                    (~key_edge_ff & ~key_prev_ff & key_sync2_ff);

  // stopwatch 100/10/1 hz on bits 6..4, clock timer 32/8/2/1 hz on 3..0
  assign tick_set = {1'b0, sw_prev_ff & ~i_stopwatch_sig,
                     ct_prev_ff & ~i_clocktimer_sig};

  // serial error, receive done, transmit done on bits 2..0
  assign ser_set = {5'h00, i_ser_error, i_ser_rx_done, i_ser_tx_done};

  // timer k underflow to bit 2k, compare match to bit 2k+1
  assign tmr_set = {i_tmr_match[3], i_tmr_underflow[3], i_tmr_match[2], i_tmr_underflow[2],
                    i_tmr_match[1], i_tmr_underflow[1], i_tmr_match[0], i_tmr_underflow[0]};

  // ----------------------------------------
  // write-one-to-clear strobes
  // ----------------------------------------
  assign tick_clr = (wr_go && wstrb0_ff && aw_idx_ff == `PIU_IDX_TICK_PEND) ?
                    (wdata_ff & `PIU_WMASK_TICK_PEND) : `PIU_RST_BYTE;
  assign ser_clr = (wr_go && wstrb0_ff && aw_idx_ff == `PIU_IDX_SER_PEND) ?
                   (wdata_ff & `PIU_WMASK_SER) : `PIU_RST_BYTE;
  assign key_clr = (wr_go && wstrb0_ff && aw_idx_ff == `PIU_IDX_KEY_PEND) ?
                   wdata_ff : `PIU_RST_BYTE;
  assign tmr_clr = (wr_go && wstrb0_ff && aw_idx_ff == `PIU_IDX_TMR_PEND) ?
                   wdata_ff : `PIU_RST_BYTE;

  // ----------------------------------------
  // pending flags
  // ----------------------------------------
  // sticky flags; a set in the clearing cycle survives
  always @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      tick_pend_ff <= `PIU_RST_BYTE;
      ser_pend_ff <= `PIU_RST_BYTE;
      key_pend_ff <= `PIU_RST_BYTE;
      tmr_pend_ff <= `PIU_RST_BYTE;
      nmi_pend_ff <= 1'b0;
    end else begin
      tick_pend_ff <= tick_set | (tick_pend_ff & ~tick_clr);
      ser_pend_ff <= ser_set | (ser_pend_ff & ~ser_clr);
      key_pend_ff <= key_edge | (key_pend_ff & ~key_clr);
      tmr_pend_ff <= tmr_set | (tmr_pend_ff & ~tmr_clr);
      nmi_pend_ff <= i_wdt_nmi | (nmi_pend_ff & ~take_nmi);
    end
  end

  // ----------------------------------------
  // enable, priority and edge-select registers
  // ----------------------------------------
  always @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      pri_a_ff <= `PIU_RST_BYTE;
      pri_b_ff <= `PIU_RST_BYTE;
      tick_en_ff <= `PIU_RST_BYTE;
      ser_en_ff <= `PIU_RST_BYTE;
      key_en_ff <= `PIU_RST_BYTE;
      tmr_en_ff <= `PIU_RST_BYTE;
      key_edge_ff <= `PIU_RST_BYTE;
    end else if (wr_go && wstrb0_ff) begin
      case (aw_idx_ff)
        `PIU_IDX_PRI_A: pri_a_ff <= wdata_ff;
        `PIU_IDX_PRI_B: pri_b_ff <= wdata_ff & `PIU_WMASK_PRI_B;
        `PIU_IDX_TICK_EN: tick_en_ff <= wdata_ff & `PIU_WMASK_TICK_EN;
        `PIU_IDX_SER_EN: ser_en_ff <= wdata_ff & `PIU_WMASK_SER;
        `PIU_IDX_KEY_EN: key_en_ff <= wdata_ff & `PIU_WMASK_FULL;
        `PIU_IDX_TMR_EN: tmr_en_ff <= wdata_ff & `PIU_WMASK_FULL;
        `PIU_IDX_KEY_EDGE: key_edge_ff <= wdata_ff;
        default: key_edge_ff <= key_edge_ff;
      endcase
    end
  end

  // ----------------------------------------
  // per-source request and level, in vector order
  // ----------------------------------------
  // index 0 is key 7, 8..15 timer bits, 16..18 serial, 19..25 ticks
  genvar g;
  generate
    for (g = 0; g < `PIU_NUM_SRC; g = g + 1) begin : g_src
      if (g < 8) begin : g_key
        assign req[g] = key_pend_ff[7-g] & key_en_ff[7-g];
        assign lvl[2*g+1:2*g] = pri_a_ff[`PIU_POS_KEY_PRI+1:`PIU_POS_KEY_PRI];
      end else if (g < 12) begin : g_t10
        assign req[g] = tmr_pend_ff[g-8] & tmr_en_ff[g-8];
        assign lvl[2*g+1:2*g] = pri_b_ff[`PIU_POS_T10_PRI+1:`PIU_POS_T10_PRI];
      end else if (g < 16) begin : g_t32
        assign req[g] = tmr_pend_ff[g-8] & tmr_en_ff[g-8];
        assign lvl[2*g+1:2*g] = pri_b_ff[`PIU_POS_T32_PRI+1:`PIU_POS_T32_PRI];
      end else if (g < 19) begin : g_ser
        assign req[g] = ser_pend_ff[18-g] & ser_en_ff[18-g];
        assign lvl[2*g+1:2*g] = pri_a_ff[`PIU_POS_SER_PRI+1:`PIU_POS_SER_PRI];
      end else if (g < 22) begin : g_sw
        assign req[g] = tick_pend_ff[25-g] & tick_en_ff[25-g];
        assign lvl[2*g+1:2*g] = pri_a_ff[`PIU_POS_SW_PRI+1:`PIU_POS_SW_PRI];
      end else begin : g_ct
        assign req[g] = tick_pend_ff[25-g] & tick_en_ff[25-g];
        assign lvl[2*g+1:2*g] = pri_a_ff[`PIU_POS_CT_PRI+1:`PIU_POS_CT_PRI];
      end
    end
  endgenerate

  // ----------------------------------------
  // arbitration
  // ----------------------------------------
  // scan low priority first so the earliest slot wins a tie
  always @* begin
    best_lvl = 2'h0;
    best_vec = `PIU_VEC_BASE;
    best_hit = 1'b0;
    for (i = `PIU_NUM_SRC - 1; i >= 0; i = i - 1) begin
      if (req[i] && lvl[2*i+:2] != 2'h0 && lvl[2*i+:2] >= best_lvl) begin
        best_lvl = lvl[2*i+:2];
        best_hit = 1'b1;
        // reserved slot after the timers is skipped
        if (i < `PIU_SRC_GAP) begin
          best_vec = `PIU_VEC_BASE + {i[6:0], 1'b0};
        end else begin
          best_vec = `PIU_VEC_SKIP + {i[6:0], 1'b0};
        end
      end
    end
  end

  // watchdog outranks the mask; maskable needs level above the mask
  assign take_nmi = i_opfetch_first & nmi_pend_ff;
  assign accept = take_nmi |
                  (i_opfetch_first & best_hit & (best_lvl > o_cpu_mask_ff));

  // ----------------------------------------
  // acceptance, mask load and restore
  // ----------------------------------------
  // maskable flags stay set on acceptance and the handler must clear them; the watchdog flag clears on acceptance
  always @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_exc_ff <= 1'b0;
      o_vector_ff <= `PIU_RST_BYTE;
      o_level_ff <= 3'h0;
      o_push_bank_ff <= 1'b0;
      o_cpu_mask_ff <= 2'h0;
      stk_ptr_ff <= 3'h0;
      for (j = 0; j < 4; j = j + 1) begin
        mask_stk_ff[j] <= 2'h0;
      end
    end else begin
      o_exc_ff <= accept;
      if (accept) begin
        o_vector_ff <= take_nmi ? `PIU_VEC_NMI : best_vec;
        o_level_ff <= take_nmi ? `PIU_LVL_NMI : {1'b0, best_lvl};
        o_push_bank_ff <= i_max_mode;
        o_cpu_mask_ff <= take_nmi ? `PIU_MASK_NMI : best_lvl;
        if (stk_ptr_ff < `PIU_STK_DEPTH) begin
          mask_stk_ff[stk_ptr_ff[1:0]] <= o_cpu_mask_ff;
          stk_ptr_ff <= stk_ptr_ff + 3'h1;
        end
      end else if (i_return_from_exception) begin
        if (stk_ptr_ff != 3'h0) begin
          o_cpu_mask_ff <= mask_stk_ff[stk_ptr_ff[1:0] - 2'h1];
          stk_ptr_ff <= stk_ptr_ff - 3'h1;
        end
      end else if (i_mask_wr) begin
        o_cpu_mask_ff <= i_mask_wdata;
      end
    end
  end

endmodule // piu_top
`default_nettype wire

// file: testbench/piu_top_monitor.sv
// assertion checker bound to the interrupt unit top
`default_nettype none
module piu_top_monitor (
  // clock, reset and bus handshakes
  input wire logic i_mclk, i_nrst, i_awvalid, i_wvalid, i_arvalid, i_bready,
  input wire logic o_awready_ff, o_wready_ff, o_arready_ff, o_bvalid_ff, o_rvalid_ff,
  input wire logic [1:0] o_bresp_ff,
  input wire logic [31:0] o_rdata_ff,
  // cpu side
  input wire logic i_opfetch_first, i_return_from_exception, i_max_mode, i_mask_wr,
  input wire logic o_exc_ff, o_push_bank_ff,
  input wire logic [7:0] o_vector_ff,
  input wire logic [2:0] o_level_ff,
  input wire logic [1:0] o_cpu_mask_ff
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_nrst);
  // ----------------------------------------
  // bus transfers taken by the slave
  // ----------------------------------------
  sequence s_wr_take;
    i_awvalid && o_awready_ff && i_wvalid && o_wready_ff;
  endsequence
  sequence s_rd_take;
    i_arvalid && o_arready_ff;
  endsequence
  a_wr_answer: assert property (s_wr_take |=> ##1 o_bvalid_ff)
    else $error("write not answered");
  a_rd_answer: assert property (s_rd_take |=> o_rvalid_ff && o_rdata_ff[31:8] == 24'h0)
    else $error("read not answered or upper bits set");
  a_resp_hold: assert property (o_bvalid_ff && !i_bready |=> o_bvalid_ff && $stable(o_bresp_ff))
    else $error("write response dropped");
  // ----------------------------------------
  // acceptance and entry
  // ----------------------------------------
  a_exc_pulse: assert property (o_exc_ff |=> !o_exc_ff)
    else $error("accept pulse too long");
  a_exc_fetch: assert property (o_exc_ff |-> $past(i_opfetch_first))
    else $error("accept outside fetch cycle");
  a_nmi_entry: assert property (o_exc_ff && o_level_ff == 3'h4 |-> o_cpu_mask_ff == 2'h3 && o_vector_ff == 8'h04)
    else $error("watchdog entry wrong");
  a_irq_level: assert property (o_exc_ff && o_level_ff != 3'h4
    |-> o_level_ff > {1'b0, $past(o_cpu_mask_ff)} && o_cpu_mask_ff == o_level_ff[1:0])
    else $error("level not above mask or mask not loaded");
  a_vec_slot: assert property (o_exc_ff |-> o_vector_ff >= 8'h04 && o_vector_ff <= 8'h3a
    && o_vector_ff != 8'h26 && !o_vector_ff[0])
    else $error("vector outside slots");
  a_bank_push: assert property (o_exc_ff |-> o_push_bank_ff == $past(i_max_mode))
    else $error("bank push wrong");
  a_mask_cause: assert property (!$stable(o_cpu_mask_ff)
    |-> o_exc_ff || $past(i_return_from_exception) || $past(i_mask_wr))
    else $error("mask changed without cause");
endmodule // piu_top_monitor

bind piu_top piu_top_monitor u_mon (.*);
`default_nettype wire

// file: testbench/piu_cpu_model.sv
// cpu fetch and return model at the far side
`default_nettype none
module piu_cpu_model (
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_nrst,
  // handler return request
  input wire logic i_return_from_exception_req,
  // cpu strobes
  output logic o_opfetch_first,
  output logic o_return_from_exception
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] cnt_ff;
  // four-cycle instructions, opcode fetch first, return one cycle after the request
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      cnt_ff <= 2'h0;
      o_opfetch_first <= 1'b0;
      o_return_from_exception <= 1'b0;
    end else begin
      cnt_ff <= cnt_ff + 2'h1;
      o_opfetch_first <= (cnt_ff == 2'h3);
      o_return_from_exception <= i_return_from_exception_req;
    end
  end
endmodule // piu_cpu_model
`default_nettype wire

// file: testbench/piu_tb_top.sv
// self-checking bench for the interrupt unit
`default_nettype none
`include "piu_consts.vh"
module prioritized_interrupt_unit_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic i_mclk, i_nrst, i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready, return_from_exception_req;
  logic [19:0] i_awaddr, i_araddr;
  logic [31:0] i_wdata, rd_d;
  logic [3:0] i_wstrb, i_tmr_underflow, i_tmr_match, i_clocktimer_sig;
  logic [7:0] i_key_pin;
  logic [2:0] i_stopwatch_sig;
  logic i_ser_error, i_ser_rx_done, i_ser_tx_done, i_wdt_nmi, i_max_mode, i_mask_wr;
  logic [1:0] i_mask_wdata, rd_r;
  wire o_awready_ff, o_wready_ff, o_bvalid_ff, o_arready_ff, o_rvalid_ff, o_exc_ff, o_push_bank_ff;
  wire i_opfetch_first, i_return_from_exception;
  wire [1:0] o_bresp_ff, o_rresp_ff, o_cpu_mask_ff;
  wire [31:0] o_rdata_ff;
  wire [7:0] o_vector_ff;
  wire [2:0] o_level_ff;
  int num_errors, num_checks;
  piu_top uut (.*);
  piu_cpu_model u_cpu (.i_mclk(i_mclk), .i_nrst(i_nrst), .i_return_from_exception_req(return_from_exception_req),
    .o_opfetch_first(i_opfetch_first), .o_return_from_exception(i_return_from_exception));
  // ----------------------------------------
  // clock, watchdog and verdict
  // ----------------------------------------
  initial begin
    i_mclk = 1'b0;
    forever #50 i_mclk = ~i_mclk;
  end
  initial begin
    #3000000;
    num_errors++;
    finish_test();
  end
  task automatic finish_test;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // ----------------------------------------
  // compare and bus tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e) begin
      num_errors++;
      $display("ERROR %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [17:0] idx, input logic [7:0] d, input logic [1:0] er);
    @(posedge i_mclk);
    i_awaddr <= {idx, 2'b00};
    i_wdata <= {24'h0, d};
    i_awvalid <= 1'b1;
    i_wvalid <= 1'b1;
    i_bready <= 1'b1;
    do begin
      @(posedge i_mclk);
      if (o_awready_ff) i_awvalid <= 1'b0;
      if (o_wready_ff) i_wvalid <= 1'b0;
    end while (o_bvalid_ff !== 1'b1);
    i_bready <= 1'b0;
    chk({30'h0, o_bresp_ff}, {30'h0, er});
  endtask
  task automatic rd(input logic [17:0] idx);
    @(posedge i_mclk);
    i_araddr <= {idx, 2'b00};
    i_arvalid <= 1'b1;
    i_rready <= 1'b1;
    do begin
      @(posedge i_mclk);
      if (o_arready_ff) i_arvalid <= 1'b0;
    end while (o_rvalid_ff !== 1'b1);
    i_rready <= 1'b0;
    rd_d = o_rdata_ff;
    rd_r = o_rresp_ff;
  endtask
  task automatic rdk(input logic [17:0] idx, input logic [7:0] e);
    rd(idx);
    chk(rd_d, {24'h0, e});
  endtask
  task automatic wrk(input logic [17:0] idx, input logic [7:0] d, input logic [7:0] e);
    wr(idx, d, `PIU_RESP_OKAY);
    rdk(idx, e);
  endtask
  // ----------------------------------------
  // cpu side tasks
  // ----------------------------------------
  task automatic wait_exc(input logic [7:0] v, input logic [2:0] l);
    do @(posedge i_mclk); while (o_exc_ff !== 1'b1);
    chk({24'h0, o_vector_ff}, {24'h0, v});
    chk({29'h0, o_level_ff}, {29'h0, l});
    chk({30'h0, o_cpu_mask_ff}, {30'h0, l[2] ? 2'h3 : l[1:0]});
  endtask
  task automatic no_exc(input int n);
    repeat (n) begin
      @(posedge i_mclk);
      chk({31'h0, o_exc_ff}, 32'h0);
    end
  endtask
  task automatic ret;
    @(posedge i_mclk);
    return_from_exception_req <= 1'b1;
    @(posedge i_mclk);
    return_from_exception_req <= 1'b0;
  endtask
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    {i_nrst, i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready, return_from_exception_req} = '0;
    {i_awaddr, i_araddr, i_wdata, i_tmr_underflow, i_tmr_match, i_key_pin, i_mask_wdata} = '0;
    {i_ser_error, i_ser_rx_done, i_ser_tx_done, i_wdt_nmi, i_max_mode, i_mask_wr} = '0;
    i_wstrb = 4'hf;
    i_stopwatch_sig = 3'h7;
    i_clocktimer_sig = 4'hf;
    repeat (10) @(posedge i_mclk);
    i_nrst <= 1'b1;
    for (logic [17:0] a = `PIU_IDX_PRI_A; a <= `PIU_IDX_CPU_MASK; a++) rdk(a, 8'h00); // reset
    wr(18'h0ff30, 8'hff, `PIU_RESP_SLVERR); // unmapped write
    rd(18'h0ff30);
    chk({30'h0, rd_r}, {30'h0, `PIU_RESP_SLVERR}); // unmapped read
    wrk(`PIU_IDX_PRI_A, 8'hff, 8'hff);
    wrk(`PIU_IDX_PRI_B, 8'hff, 8'hfc);
    wrk(`PIU_IDX_TICK_EN, 8'hff, 8'hff);
    wrk(`PIU_IDX_SER_EN, 8'hff, 8'h07);
    wrk(`PIU_IDX_KEY_EN, 8'hff, 8'hff);
    wrk(`PIU_IDX_TMR_EN, 8'hff, 8'hff);
    for (logic [17:0] a = `PIU_IDX_PRI_A; a <= `PIU_IDX_TMR_EN; a++) wrk(a, 8'h00, 8'h00);
    // every kind of maskable source event in one cycle
    i_tmr_underflow <= 4'h5;
    i_tmr_match <= 4'ha;
    {i_ser_error, i_ser_rx_done, i_ser_tx_done} <= 3'b111;
    i_stopwatch_sig <= 3'h0;
    i_clocktimer_sig <= 4'h0;
    i_key_pin <= 8'hff;
    @(posedge i_mclk);
    {i_tmr_underflow, i_tmr_match, i_ser_error, i_ser_rx_done, i_ser_tx_done} <= '0;
    rdk(`PIU_IDX_TMR_PEND, 8'h99); // underflow 2k, match 2k+1
    rdk(`PIU_IDX_SER_PEND, 8'h07);
    rdk(`PIU_IDX_TICK_PEND, 8'h7f);
    rdk(`PIU_IDX_KEY_PEND, 8'hff); // rising edges
    wr(`PIU_IDX_TMR_PEND, 8'h81, `PIU_RESP_OKAY);
    rdk(`PIU_IDX_TMR_PEND, 8'h18);
    wr(`PIU_IDX_KEY_PEND, 8'hff, `PIU_RESP_OKAY);
    wr(`PIU_IDX_KEY_EDGE, 8'hf0, `PIU_RESP_OKAY);
    i_key_pin <= 8'h00;
    repeat (4) @(posedge i_mclk);
    rdk(`PIU_IDX_KEY_PEND, 8'hf0); // only falling-selected pins
    // timer requests at levels 3 and 2, served one after another
    wr(`PIU_IDX_TMR_EN, 8'hff, `PIU_RESP_OKAY);
    wr(`PIU_IDX_PRI_B, 8'h38, `PIU_RESP_OKAY);
    wait_exc(8'h1e, 3'h3);
    ret();
    wait_exc(8'h1e, 3'h3); // flag left set
    wr(`PIU_IDX_TMR_PEND, 8'h10, `PIU_RESP_OKAY);
    ret();
    wait_exc(8'h1c, 3'h2);
    wr(`PIU_IDX_TMR_PEND, 8'h08, `PIU_RESP_OKAY);
    ret();
    no_exc(12);
    rdk(`PIU_IDX_CPU_MASK, 8'h00);
    // level 0 systems stay silent, then equal levels tie
    wr(`PIU_IDX_SER_EN, 8'h07, `PIU_RESP_OKAY);
    wr(`PIU_IDX_TICK_EN, 8'hff, `PIU_RESP_OKAY);
    no_exc(12);
    wr(`PIU_IDX_PRI_A, 8'h14, `PIU_RESP_OKAY);
    wait_exc(8'h28, 3'h1); // serial error before stopwatch
    chk({31'h0, o_push_bank_ff}, 32'h0);
    // watchdog beats a full mask
    i_mask_wr <= 1'b1;
    i_mask_wdata <= 2'h3;
    @(posedge i_mclk);
    i_mask_wr <= 1'b0;
    i_max_mode <= 1'b1;
    i_wdt_nmi <= 1'b1;
    @(posedge i_mclk);
    i_wdt_nmi <= 1'b0;
    wait_exc(`PIU_VEC_NMI, `PIU_LVL_NMI);
    chk({31'h0, o_push_bank_ff}, 32'h1);
    finish_test();
  end
endmodule // prioritized_interrupt_unit_tb_top
`default_nettype wire
